// *** include/swrl_defs.svh ***
`ifndef SWRL_DEFS_SVH
`define SWRL_DEFS_SVH
// Function
// - Host alone opens a frame; the device only emits interrupt pulses.
// - Frame: start 3, opcode 3, address 5, guard 1, data 8, parity 2.
// - Write frames add one turnaround guard then two device acknowledge bits.
// - Start field follows polarity; its middle bit's length sets the bit period.
// - Opcode 1,1,0 reads, 0,1,1 writes; anything else is no access.
// - Guard bits only allow turnaround; their sampled value means nothing.
// - First parity bit is odd parity of opcode, address, data; second inverts it. The code sends and checks the XOR of those fields (even parity).
// - After the write guard, device returns both parity bits as acknowledge.
// - Bit periods up to 1024 output clock cycles are measured; longer aborts.
// - The link runs on the device output clock at any running rate.
// - Polarity is programmable; idle line weakly pulled to the inactive level.
// - One pin carries both transfer directions and the interrupt request.
// - Five-bit address reaches 36 registers, some through a page select.
// - An interrupt drives the active level four clocks, then goes inactive.
// - Interrupt polarity lives in bit 6 of register 0x11.
// - Wakeup timer end of count raises an interrupt pulse on the line.

// Field widths
`define SWRL_ADDR_W        5
`define SWRL_DATA_W        8
`define SWRL_OP_W          3
`define SWRL_PER_W         11
`define SWRL_IDX_W         5
`define SWRL_TX_W          10

// Opcodes, first received bit in the msb
`define SWRL_OP_READ       3'h6
`define SWRL_OP_WRITE      3'h3

// Bit period limits in output clock cycles
`define SWRL_MIN_PERIOD    11'h004
`define SWRL_MAX_PERIOD    11'h400

// Interrupt pulse length in output clock cycles
`define SWRL_IRQ_CYCLES    3'h4

// Bit positions in a frame, third start bit is position 0
`define SWRL_IDX_OP_FIRST  5'h01
`define SWRL_IDX_OP_LAST   5'h03
`define SWRL_IDX_ADDR_FIRST 5'h04
`define SWRL_IDX_ADDR_LAST 5'h08
`define SWRL_IDX_GUARD0    5'h09
`define SWRL_IDX_DATA_FIRST 5'h0a
`define SWRL_IDX_DATA_LAST 5'h11
`define SWRL_IDX_PAR0      5'h12
`define SWRL_IDX_PAR1      5'h13
`define SWRL_IDX_ACK0      5'h15
`define SWRL_IDX_ACK1      5'h16
`define SWRL_IDX_RD_END    5'h15
`define SWRL_IDX_WR_END    5'h18

// Register bank
`define SWRL_NUM_REGS      32
`define SWRL_NUM_PAGED     4
`define SWRL_PIDX_W        2
`define SWRL_REG_POL       5'h11
`define SWRL_POL_BIT       6
`define SWRL_REG_PAGE      5'h1f
`define SWRL_PAGE_BIT      0
`define SWRL_PAGED_BASE    5'h1b
`define SWRL_PAGED_LAST    5'h1e
`define SWRL_REG_RST       8'h00

`endif

// *** include/swrl_pkg.sv ***
`include "swrl_defs.svh"
package swrl_pkg;

  typedef logic [`SWRL_ADDR_W-1:0] swrl_addr_t;
  typedef logic [`SWRL_DATA_W-1:0] swrl_data_t;

  typedef enum logic [2:0] {
    SWRL_WAIT_IDLE = 3'h0,
    SWRL_IDLE      = 3'h1,
    SWRL_START1    = 3'h2,
    SWRL_START2    = 3'h3,
    SWRL_FRAME     = 3'h4,
    SWRL_IRQ       = 3'h5
  } swrl_state_t;

endpackage

// *** src/swrl_bit_clock.sv ***
`timescale 1ns/1ps
`include "swrl_defs.svh"
module swrl_bit_clock #(
  parameter int unsigned PER_W = `SWRL_PER_W
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // Bit timing
  input  wire logic             run,
  input  wire logic [PER_W-1:0] period,
  output logic                  bit_end,
  output logic                  bit_mid
);

  logic [PER_W-1:0] cnt_ff;

  // Cycle count within the current bit
  always_ff @(posedge clk) begin
    if (srst || !run) begin
      cnt_ff <= '0;
    end else if (bit_end) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  assign bit_end = run && (cnt_ff == period - 1'b1);
  assign bit_mid = run && (cnt_ff == (period >> 1));

endmodule

// *** src/swrl_link.sv ***
`timescale 1ns/1ps
`include "swrl_defs.svh"
module swrl_link #(
  parameter int unsigned PER_W = `SWRL_PER_W
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 srst,
  // Shared serial and interrupt pin
  input  wire logic                 line_in,
  output logic                      line_out,
  output logic                      line_oe,
  output logic                      line_pull_level,
  // Wakeup timer event
  input  wire logic                 timer_expire,
  // Register bank view
  output logic                      irq_polarity,
  output logic                      reg_wr_stb,
  output swrl_pkg::swrl_addr_t      reg_wr_addr,
  output logic                      reg_wr_paged,
  output swrl_pkg::swrl_data_t      reg_wr_data,
  output logic                      reg_rd_stb,
  output swrl_pkg::swrl_addr_t      reg_rd_addr,
  // Link status
  output logic                      frame_busy,
  output logic                      frame_err
);
  import swrl_pkg::*;

  logic                       line_meta_ff;
  logic                       line_sync_ff;
  swrl_state_t                state_ff;
  swrl_state_t                nxt_state;
  logic [PER_W-1:0]           meas_ff;
  logic [PER_W-1:0]           period_ff;
  logic [`SWRL_IDX_W-1:0]     idx_ff;
  logic [`SWRL_IDX_W-1:0]     nxt_idx;
  logic [`SWRL_OP_W-1:0]      op_ff;
  logic                       is_wr_ff;
  swrl_addr_t                 addr_ff;
  swrl_data_t                 data_ff;
  logic                       p0_rx_ff;
  logic                       ack_ok_ff;
  logic [`SWRL_TX_W-1:0]      tx_ff;
  logic [2:0]                 irq_cnt_ff;
  logic                       pend_ff;
  logic                       line_out_ff;
  logic                       line_oe_ff;
  logic                       pull_ff;
  logic                       wr_stb_ff;
  swrl_addr_t                 wr_addr_ff;
  logic                       wr_paged_ff;
  swrl_data_t                 wr_data_ff;
  logic                       rd_stb_ff;
  swrl_addr_t                 rd_addr_ff;
  logic                       err_ff;
  swrl_data_t                 bank_ff [`SWRL_NUM_REGS];
  swrl_data_t                 page_bank_ff [`SWRL_NUM_PAGED];
  logic                       bit_end;
  logic                       bit_mid;
  logic                       run;
  logic                       pol;
  logic                       act;
  logic                       paged_hit;
  logic [`SWRL_PIDX_W-1:0]    pidx;
  swrl_data_t                 rd_data;
  logic [`SWRL_OP_W-1:0]      op_now;
  logic                       op_bad;
  logic                       par_tx;
  logic                       par_wr;
  logic                       commit;
  logic                       par_bad;
  logic                       per_bad;
  logic                       drive_win;
  logic [`SWRL_IDX_W-1:0]     end_idx;

  // Pin synchroniser
  always_ff @(posedge clk) begin
    if (srst) begin
      line_meta_ff <= 1'b0;
      line_sync_ff <= 1'b0;
    end else begin
      line_meta_ff <= line_in;
      line_sync_ff <= line_meta_ff;
    end
  end

  // Polarity decode and address mapping
  assign pol       = bank_ff[`SWRL_REG_POL][`SWRL_POL_BIT];
  assign act       = (line_sync_ff == pol);
  assign paged_hit = bank_ff[`SWRL_REG_PAGE][`SWRL_PAGE_BIT] &&
                     (addr_ff >= `SWRL_PAGED_BASE) && (addr_ff <= `SWRL_PAGED_LAST);
  assign pidx      = `SWRL_PIDX_W'(addr_ff - `SWRL_PAGED_BASE);
  assign rd_data   = paged_hit ? page_bank_ff[pidx] : bank_ff[addr_ff];
  assign op_now    = {op_ff[`SWRL_OP_W-2:0], line_sync_ff};
  assign op_bad    = (op_now != `SWRL_OP_READ) && (op_now != `SWRL_OP_WRITE);
  assign par_tx    = (^op_ff) ^ (^addr_ff) ^ (^rd_data);
  assign par_wr    = (^op_ff) ^ (^addr_ff) ^ (^data_ff);
  assign run       = (state_ff == SWRL_FRAME);
  assign end_idx   = is_wr_ff ? `SWRL_IDX_WR_END : `SWRL_IDX_RD_END;
  assign nxt_idx   = idx_ff + 1'b1;
  assign per_bad   = (meas_ff < `SWRL_MIN_PERIOD);

  assign commit = run && bit_mid && is_wr_ff && (idx_ff == `SWRL_IDX_PAR1) &&
                  (p0_rx_ff == par_wr) && (line_sync_ff != p0_rx_ff);
  assign par_bad = run && bit_mid && is_wr_ff && (idx_ff == `SWRL_IDX_PAR1) && !commit;

  // Output window for the next bit position
  always_comb begin
    if (is_wr_ff) begin
      drive_win = ack_ok_ff && (nxt_idx >= `SWRL_IDX_ACK0) && (nxt_idx <= `SWRL_IDX_ACK1);
    end else begin
      drive_win = (nxt_idx >= `SWRL_IDX_DATA_FIRST) && (nxt_idx <= `SWRL_IDX_PAR1);
    end
  end

  swrl_bit_clock #(
    .PER_W   (PER_W)
  ) u_bit_clock (
    .clk     (clk),
    .srst    (srst),
    .run     (run),
    .period  (period_ff),
    .bit_end (bit_end),
    .bit_mid (bit_mid)
  );

  // Link state machine
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      SWRL_WAIT_IDLE: begin
        if (!act) begin
          nxt_state = SWRL_IDLE;
        end
      end
      SWRL_IDLE: begin
        if (act) begin
          nxt_state = SWRL_START1;
        end else if (pend_ff) begin
          nxt_state = SWRL_IRQ;
        end
      end
      SWRL_START1: begin
        if (!act) begin
          nxt_state = SWRL_START2;
        end else if (meas_ff >= `SWRL_MAX_PERIOD) begin
          nxt_state = SWRL_WAIT_IDLE;
        end
      end
      SWRL_START2: begin
        if (act) begin
          nxt_state = per_bad ? SWRL_WAIT_IDLE : SWRL_FRAME;
        end else if (meas_ff >= `SWRL_MAX_PERIOD) begin
          nxt_state = SWRL_WAIT_IDLE;
        end
      end
      SWRL_FRAME: begin
        if (bit_mid && (idx_ff == `SWRL_IDX_OP_LAST) && op_bad) begin
          nxt_state = SWRL_WAIT_IDLE;
        end else if (bit_end && (idx_ff == end_idx)) begin
          nxt_state = SWRL_WAIT_IDLE;
        end
      end
      SWRL_IRQ: begin
        if (irq_cnt_ff == `SWRL_IRQ_CYCLES) begin
          nxt_state = SWRL_WAIT_IDLE;
        end
      end
      default: begin
        nxt_state = SWRL_WAIT_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff <= SWRL_WAIT_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Start field period measurement
  always_ff @(posedge clk) begin
    if (srst) begin
      meas_ff   <= '0;
      period_ff <= `SWRL_MAX_PERIOD;
    end else if (state_ff == SWRL_START1) begin
      meas_ff <= act ? meas_ff + 1'b1 : PER_W'(1);
    end else if (state_ff == SWRL_START2) begin
      if (act) begin
        period_ff <= meas_ff;
      end else begin
        meas_ff <= meas_ff + 1'b1;
      end
    end else if (state_ff != SWRL_FRAME) begin
      meas_ff <= '0;
    end
  end

  // Bit position within the frame
  always_ff @(posedge clk) begin
    if (srst || !run) begin
      idx_ff <= '0;
    end else if (bit_end) begin
      idx_ff <= nxt_idx;
    end
  end

  // Received fields, sampled mid-bit; guard positions are skipped
  always_ff @(posedge clk) begin
    if (srst) begin
      op_ff     <= '0;
      is_wr_ff  <= 1'b0;
      addr_ff   <= '0;
      data_ff   <= '0;
      p0_rx_ff  <= 1'b0;
      ack_ok_ff <= 1'b0;
    end else if (state_ff == SWRL_START1) begin
      ack_ok_ff <= 1'b0;
    end else if (run && bit_mid) begin
      if ((idx_ff >= `SWRL_IDX_OP_FIRST) && (idx_ff <= `SWRL_IDX_OP_LAST)) begin
        op_ff <= op_now;
      end
      if (idx_ff == `SWRL_IDX_OP_LAST) begin
        is_wr_ff <= (op_now == `SWRL_OP_WRITE);
      end
      if ((idx_ff >= `SWRL_IDX_ADDR_FIRST) && (idx_ff <= `SWRL_IDX_ADDR_LAST)) begin
        addr_ff <= {line_sync_ff, addr_ff[`SWRL_ADDR_W-1:1]};
      end
      if (is_wr_ff && (idx_ff >= `SWRL_IDX_DATA_FIRST) && (idx_ff <= `SWRL_IDX_DATA_LAST)) begin
        data_ff <= {line_sync_ff, data_ff[`SWRL_DATA_W-1:1]};
      end
      if (idx_ff == `SWRL_IDX_PAR0) begin
        p0_rx_ff <= line_sync_ff;
      end
      if (idx_ff == `SWRL_IDX_PAR1) begin
        ack_ok_ff <= commit;
      end
    end
  end

  // Register bank, reset to defaults
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < `SWRL_NUM_REGS; i++) begin
        bank_ff[i] <= `SWRL_REG_RST;
      end
      for (int j = 0; j < `SWRL_NUM_PAGED; j++) begin
        page_bank_ff[j] <= `SWRL_REG_RST;
      end
    end else if (commit) begin
      if (paged_hit) begin
        page_bank_ff[pidx] <= data_ff;
      end else begin
        bank_ff[addr_ff] <= data_ff;
      end
    end
  end

  // Register access strobes for the rest of the chip
  always_ff @(posedge clk) begin
    if (srst) begin
      wr_stb_ff   <= 1'b0;
      wr_addr_ff  <= '0;
      wr_paged_ff <= 1'b0;
      wr_data_ff  <= '0;
      rd_stb_ff   <= 1'b0;
      rd_addr_ff  <= '0;
    end else begin
      wr_stb_ff <= commit;
      rd_stb_ff <= run && bit_mid && !is_wr_ff && (idx_ff == `SWRL_IDX_GUARD0);
      if (commit) begin
        wr_addr_ff  <= addr_ff;
        wr_paged_ff <= paged_hit;
        wr_data_ff  <= data_ff;
      end
      if (run && bit_mid && !is_wr_ff && (idx_ff == `SWRL_IDX_GUARD0)) begin
        rd_addr_ff <= addr_ff;
      end
    end
  end

  // Pending interrupt, a new event beats the clear
  always_ff @(posedge clk) begin
    if (srst) begin
      pend_ff <= 1'b0;
    end else if (timer_expire) begin
      pend_ff <= 1'b1;
    end else if ((state_ff == SWRL_IDLE) && (nxt_state == SWRL_IRQ)) begin
      pend_ff <= 1'b0;
    end
  end

  // Pin drive: interrupt pulse, read data and write acknowledge
  always_ff @(posedge clk) begin
    if (srst) begin
      line_out_ff <= 1'b0;
      line_oe_ff  <= 1'b0;
      tx_ff       <= '0;
      irq_cnt_ff  <= '0;
    end else if (state_ff == SWRL_IRQ) begin
      if (irq_cnt_ff < `SWRL_IRQ_CYCLES) begin
        line_oe_ff  <= 1'b1;
        line_out_ff <= pol;
        irq_cnt_ff  <= irq_cnt_ff + 1'b1;
      end else begin
        line_oe_ff  <= 1'b0;
      end
    end else if (run) begin
      irq_cnt_ff <= '0;
      if (bit_mid && !is_wr_ff && (idx_ff == `SWRL_IDX_GUARD0)) begin
        tx_ff <= {~par_tx, par_tx, rd_data};
      end else if (commit) begin
        tx_ff <= {{`SWRL_DATA_W{1'b0}}, ~p0_rx_ff, p0_rx_ff};
      end else if (bit_end) begin
        if (drive_win) begin
          line_oe_ff  <= 1'b1;
          line_out_ff <= tx_ff[0];
          tx_ff       <= tx_ff >> 1;
        end else begin
          line_oe_ff  <= 1'b0;
        end
      end
    end else begin
      irq_cnt_ff <= '0;
      line_oe_ff <= 1'b0;
    end
  end

  // Idle pull level, status and error flags
  always_ff @(posedge clk) begin
    if (srst) begin
      pull_ff <= 1'b1;
      err_ff  <= 1'b0;
    end else begin
      pull_ff <= ~pol;
      err_ff  <= ((state_ff == SWRL_FRAME) && bit_mid && (idx_ff == `SWRL_IDX_OP_LAST) && op_bad) ||
                 par_bad ||
                 ((state_ff == SWRL_START2) && act && per_bad) ||
                 ((state_ff == SWRL_START2) && !act && (meas_ff >= `SWRL_MAX_PERIOD));
    end
  end

  // Everything runs on clk, the device output clock
  assign line_out        = line_out_ff;
  assign line_oe         = line_oe_ff;
  assign line_pull_level = pull_ff;
  assign irq_polarity    = pol;
  assign reg_wr_stb      = wr_stb_ff;
  assign reg_wr_addr     = wr_addr_ff;
  assign reg_wr_paged    = wr_paged_ff;
  assign reg_wr_data     = wr_data_ff;
  assign reg_rd_stb      = rd_stb_ff;
  assign reg_rd_addr     = rd_addr_ff;
  assign frame_busy      = (state_ff != SWRL_IDLE);
  assign frame_err       = err_ff;

endmodule

// *** bench/swrl_link_properties.sv ***
`timescale 1ns/1ps
`include "swrl_defs.svh"
module swrl_link_properties
  import swrl_pkg::*;
#(
  parameter int unsigned PER_W = `SWRL_PER_W
) (
  // Clock and reset
  input wire logic       clk,
  input wire logic       srst,
  // Pin
  input wire logic       line_out,
  input wire logic       line_oe,
  input wire logic       line_pull_level,
  // Register view
  input wire logic       irq_polarity,
  input wire logic       reg_wr_stb,
  input swrl_addr_t      reg_wr_addr,
  input swrl_data_t      reg_wr_data,
  input wire logic       reg_rd_stb,
  // Status
  input wire logic       frame_busy,
  input wire logic       frame_err
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  pull_level_a: assert property (!$changed(irq_polarity) |-> line_pull_level == !irq_polarity)
    else $error("pull level not inverse of polarity");
  idle_release_a: assert property (line_oe |-> frame_busy)
    else $error("pin driven outside frame or interrupt");
  drive_len_a: assert property ($rose(line_oe) |-> line_oe [*4])
    else $error("drive shorter than four cycles");
  wr_pulse_a: assert property (reg_wr_stb |=> !reg_wr_stb)
    else $error("write strobe longer than one cycle");
  rd_pulse_a: assert property (reg_rd_stb |=> !reg_rd_stb)
    else $error("read strobe longer than one cycle");
  err_pulse_a: assert property (frame_err |=> !frame_err)
    else $error("error pulse longer than one cycle");
  wr_hold_a: assert property (!reg_wr_stb |-> $stable(reg_wr_data))
    else $error("write data moved without a write");
  pol_write_a: assert property ($changed(irq_polarity) |-> ##[0:1] (reg_wr_stb && reg_wr_addr == `SWRL_REG_POL))
    else $error("polarity changed without register write");
endmodule
bind swrl_link swrl_link_properties #(.PER_W(PER_W)) swrl_link_properties_i (
  .clk(clk), .srst(srst), .line_out(line_out), .line_oe(line_oe), .line_pull_level(line_pull_level),
  .irq_polarity(irq_polarity), .reg_wr_stb(reg_wr_stb), .reg_wr_addr(reg_wr_addr),
  .reg_wr_data(reg_wr_data), .reg_rd_stb(reg_rd_stb), .frame_busy(frame_busy), .frame_err(frame_err)
);

// *** bench/swrl_host_model.sv ***
`timescale 1ns/1ps
module swrl_host_model (
  // Clock
  input wire logic clk,
  // Resolved pin
  input wire logic line,
  output logic     host_drv,
  output logic     host_oe
);
  initial begin
    host_drv = 1'b1;
    host_oe  = 1'b0;
  end

  // Drive one bit for a whole period
  task automatic put(input logic v, input int per);
    host_oe  = 1'b1;
    host_drv = v;
    repeat (per) @(negedge clk);
  endtask

  // Host opens every frame
  task automatic xfer(input logic [2:0] op, input logic [4:0] a, input logic [7:0] d, input int per,
                      input logic pol, input logic bad, output logic [9:0] got);
    logic [21:0] v;
    logic        p0;
    int          n;
    p0 = ^{op, a, d} ^ bad;
    v = {~p0, p0, d, ~pol, a, op[0], op[1], op[2], pol, ~pol, pol};
    // Refused opcodes release the line after the opcode
    n = (op == 3'h6) ? 11 : ((op == 3'h3) ? 22 : 6);
    for (int i = 0; i < n; i++) begin
      put(v[i], per);
    end
    host_oe = 1'b0;
    // Device bits lag the host boundary by two and a half clocks
    repeat (per + 2) @(negedge clk);
    got = '1;
    for (int i = 0; i < ((n == 11) ? 10 : 2); i++) begin
      repeat (per / 2) @(negedge clk);
      got[i] = line;
      repeat (per - per / 2) @(negedge clk);
    end
    repeat (2 * per) @(negedge clk);
  endtask

  // Start then a middle bit that never ends
  task automatic overlong(input int per, input logic pol);
    put(pol, 8);
    host_oe = 1'b0;
    repeat (per) @(negedge clk);
  endtask
endmodule

// *** bench/swrl_link_test.sv ***
`timescale 1ns/1ps
module swrl_link_test;
  import swrl_pkg::*;
  logic       clk = 1'b0;
  logic       srst = 1'b1;
  logic       timer_expire = 1'b0;
  wire logic  line_in;
  logic       line_out, line_oe, line_pull_level, irq_polarity;
  logic       reg_wr_stb, reg_wr_paged, reg_rd_stb, frame_busy, frame_err;
  swrl_addr_t reg_wr_addr, reg_rd_addr;
  swrl_data_t reg_wr_data;
  logic       host_drv, host_oe;
  int         miscompares, total_checks, cycles, errs, wrs, rds;
  logic [9:0] got;

  always #4 clk = ~clk;
  assign line_in = line_oe ? line_out : (host_oe ? host_drv : line_pull_level);

  swrl_link swrl_link_i (.clk(clk), .srst(srst), .line_in(line_in), .line_out(line_out),
    .line_oe(line_oe), .line_pull_level(line_pull_level), .timer_expire(timer_expire),
    .irq_polarity(irq_polarity), .reg_wr_stb(reg_wr_stb), .reg_wr_addr(reg_wr_addr),
    .reg_wr_paged(reg_wr_paged), .reg_wr_data(reg_wr_data), .reg_rd_stb(reg_rd_stb),
    .reg_rd_addr(reg_rd_addr), .frame_busy(frame_busy), .frame_err(frame_err));
  swrl_host_model swrl_host_model_i (.clk(clk), .line(line_in), .host_drv(host_drv), .host_oe(host_oe));

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    errs <= errs + int'(frame_err === 1'b1);
    wrs <= wrs + int'(reg_wr_stb === 1'b1);
    rds <= rds + int'(reg_rd_stb === 1'b1);
    if (cycles == 100000) begin
      miscompares++;
      conclude();
    end
  end

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 3000 && frame_busy !== 1'b0; i++) @(negedge clk);
    check("idle", 32'h0, {31'h0, frame_busy});
  endtask

  task automatic do_wr(input logic [4:0] a, input logic [7:0] d, input int per, input logic pol);
    logic p0;
    p0 = ^{3'h3, a, d};
    swrl_host_model_i.xfer(3'h3, a, d, per, pol, 1'b0, got);
    check("ack", {30'h0, ~p0, p0}, {30'h0, got[1:0]});
    check("wr_addr", {27'h0, a}, {27'h0, reg_wr_addr});
    check("wr_data", {24'h0, d}, {24'h0, reg_wr_data});
    wait_idle();
  endtask

  task automatic do_rd(input logic [4:0] a, input logic [7:0] e, input int per, input logic pol);
    logic p0;
    p0 = ^{3'h6, a, e};
    swrl_host_model_i.xfer(3'h6, a, 8'h00, per, pol, 1'b0, got);
    check("rd_frame", {22'h0, ~p0, p0, e}, {22'h0, got});
    check("rd_addr", {27'h0, a}, {27'h0, reg_rd_addr});
    wait_idle();
  endtask

  task automatic t_reset();
    check("oe", 32'h0, {31'h0, line_oe});
    check("pull", 32'h1, {31'h0, line_pull_level});
    check("pol", 32'h0, {31'h0, irq_polarity});
    wait_idle();
  endtask

  task automatic t_basic();
    int w, r;
    w = wrs;
    r = rds;
    do_wr(5'h05, 8'ha5, 8, 1'b0);
    do_rd(5'h05, 8'ha5, 8, 1'b0);
    check("wr_cnt", w + 1, wrs);
    check("rd_cnt", r + 1, rds);
  endtask

  task automatic t_periods();
    do_wr(5'h06, 8'h3c, 4, 1'b0);
    do_rd(5'h06, 8'h3c, 52, 1'b0);
    do_wr(5'h07, 8'h81, 1024, 1'b0);
    do_rd(5'h07, 8'h81, 4, 1'b0);
  endtask

  task automatic t_refuse();
    int e, w;
    logic [2:0] ops [3] = '{3'h7, 3'h0, 3'h5};
    e = errs;
    w = wrs;
    foreach (ops[i]) begin
      swrl_host_model_i.xfer(ops[i], 5'h05, 8'h11, 8, 1'b0, 1'b0, got);
      wait_idle();
    end
    swrl_host_model_i.xfer(3'h3, 5'h05, 8'h22, 8, 1'b0, 1'b1, got);
    check("no_ack", 32'h3, {30'h0, got[1:0]});
    wait_idle();
    swrl_host_model_i.overlong(1100, 1'b0);
    wait_idle();
    check("err_cnt", e + 5, errs);
    check("wr_none", w, wrs);
    do_rd(5'h05, 8'ha5, 8, 1'b0);
  endtask

  task automatic t_page();
    do_wr(5'h1f, 8'h01, 8, 1'b0);
    do_wr(5'h1b, 8'h5a, 8, 1'b0);
    check("paged", 32'h1, {31'h0, reg_wr_paged});
    do_rd(5'h1b, 8'h5a, 8, 1'b0);
    do_wr(5'h1f, 8'h00, 8, 1'b0);
    do_rd(5'h1b, 8'h00, 8, 1'b0);
  endtask

  task automatic irq_len(input logic pol);
    int n;
    n = 0;
    timer_expire = 1'b1;
    @(negedge clk);
    timer_expire = 1'b0;
    repeat (30) begin
      @(negedge clk);
      n += int'(line_oe === 1'b1 && line_out === pol);
    end
    check("irq_len", 32'h4, n);
    wait_idle();
  endtask

  task automatic t_irq();
    irq_len(1'b0);
    do_wr(5'h11, 8'h40, 8, 1'b0);
    check("pol_hi", 32'h1, {31'h0, irq_polarity});
    check("pull_lo", 32'h0, {31'h0, line_pull_level});
    irq_len(1'b1);
    do_rd(5'h11, 8'h40, 8, 1'b1);
  endtask

  initial begin
    repeat (10) @(negedge clk);
    srst = 1'b0;
    repeat (4) @(negedge clk);
    t_reset();
    t_basic();
    t_periods();
    t_refuse();
    t_page();
    t_irq();
    conclude();
  end
endmodule
